// *** hw/supply_monitor_fault_supervisor.sv ***
// Supervision logic: setpoints, measurement buffers, settling and fault timers
`timescale 1ns/10ps
`default_nettype none
`include "supmon_params.svh"
module supply_monitor_fault_supervisor import supmon_pkg::*; #(
	parameter int unsigned TICK_CYC = `T_LOOP_US * `CLK_MHZ,
	parameter int unsigned P6_CYC = `T_PERSIST_US * `CLK_MHZ,
	parameter int unsigned PLDET_CYC = `T_PLDET_US * `CLK_MHZ,
	parameter int unsigned P20_CYC = `T_PATHR_US * `CLK_MHZ
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Converter results, live
	input wire logic [11:0] ADC_V,
	input wire logic [11:0] ADC_I,
	// Fault sensors and straps
	input wire logic OVERTEMP,
	input wire logic POWER_LOST,
	input wire logic PATH_DROP_OUT,
	input wire logic PATH_DROP_COMMON_SENSE_LEAD,
	input wire logic POWER_LOSS_DISABLE_JUMPER,
	input wire logic SEQ_BUSY,
	// References to the converters of the analog loop
	output logic [11:0] VREF,
	output logic [11:0] IREF,
	// Interrupts
	output logic IRQ,
	output logic HP_IRQ,
	// Shutdown actions
	output logic CROWBAR,
	output logic BREAKER_TRIP,
	output logic ZERO_OUT,
	output logic RELAY_OPEN
);
	// Registered and next state
	state_t q;
	state_t d;
	// Bundled request
	bus_req_t req;
	// Loop iteration strobe
	logic tick;
	// Raw fault conditions
	logic [3:0] raw;
	// Qualification limits per timer
	logic [3:0][`TMR_W-1:0] lim;
	// Timer just reached its limit
	logic [3:0] qual;
	// Events of this cycle
	logic [`EV_W-1:0] ev;
	// Settling check helpers
	logic [11:0] cmd_meas;
	logic [11:0] cmd_set;
	logic [11:0] dev;
	logic in_win;
	// Wide thresholds avoid wrap near full scale
	logic [12:0] v_thr;
	logic [12:0] i_thr;

	assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

	// Absolute difference of two readings
	function automatic logic [11:0] absdiff(input logic [11:0] a, input logic [11:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// Fault thresholds and persistence limits
	always_comb begin
		v_thr = {1'b0, q.vset} + {1'b0, `OVC_MARGIN};
		i_thr = {1'b0, q.iset} + {1'b0, `OVC_MARGIN};
		raw[T_OVC] = ({1'b0, ADC_V} > v_thr) || ({1'b0, ADC_I} > i_thr);
		raw[T_OTMP] = OVERTEMP;
		raw[T_PLOSS] = POWER_LOST && POWER_LOSS_DISABLE_JUMPER;
		raw[T_PATH] = PATH_DROP_OUT || PATH_DROP_COMMON_SENSE_LEAD;
		lim[T_OVC] = `TMR_W'(P6_CYC);
		lim[T_OTMP] = `TMR_W'(P6_CYC);
		// Detection time then a further persistence time
		lim[T_PLOSS] = `TMR_W'(PLDET_CYC + P6_CYC);
		// Relay units wait longer before acting
		lim[T_PATH] = q.relay_var ? `TMR_W'(P20_CYC) : `TMR_W'(P6_CYC);
	end

	// Settling comparison on the commanded quantity
	always_comb begin
		cmd_meas = q.cmode ? ADC_I : ADC_V;
		cmd_set = q.cmode ? q.iset : q.vset;
		dev = absdiff(cmd_meas, cmd_set);
		in_win = dev <= `CMP_TOL;
	end

	// Next state
	always_comb begin
		d = q;
		d.rdata = 32'h0;
		ev = '0;
		qual = '0;
		// Control loop tick every 2 ms
		tick = q.tick_cnt == 18'(TICK_CYC - 1);
		d.tick_cnt = tick ? 18'h0 : q.tick_cnt + 18'h1;
		// Measurement buffers follow the converter only on a tick
		if (tick) begin
			d.vmeas = ADC_V;
			d.imeas = ADC_I;
		end
		// Persistence timers: count while raw, restart when it clears
		for (int k = 0; k < 4; k++) begin
			if (!raw[k]) begin
				d.tmr[k] = '0;
			end else if (q.tmr[k] != lim[k]) begin
				d.tmr[k] = q.tmr[k] + `TMR_W'(1);
				qual[k] = q.tmr[k] == lim[k] - `TMR_W'(1);
			end
		end
		// Overtemperature reported at onset, shutdown waits for qualification
		d.ot_prev = OVERTEMP;
		if (OVERTEMP && !q.ot_prev) begin
			ev[`S_OTMP] = 1'b1;
		end
		if (qual[T_OTMP]) begin
			ev[`S_OTMP] = 1'b1;
		end
		if (qual[T_PLOSS]) begin
			ev[`S_PLOSS] = 1'b1;
		end
		if (qual[T_PATH]) begin
			ev[`S_PATH] = 1'b1;
		end
		// Any crowbar cause; relay units handle path faults by the relays
		if (qual[T_OVC] || qual[T_OTMP] || qual[T_PLOSS] || (qual[T_PATH] && !q.relay_var)) begin
			ev[`S_CROW] = 1'b1;
			d.sd.crowbar = 1'b1;
			d.sd.trip = 1'b1;
			d.sd.zero = 1'b1;
		end
		// Path fault zeroes the references either way
		if (qual[T_PATH]) begin
			d.sd.zero = 1'b1;
			d.sd.relay_open = q.sd.relay_open | q.relay_var;
		end
		// Settling window after a programming change
		if (q.settling && tick) begin
			d.iter = q.iter + 4'h1;
			d.ok_cnt = in_win ? q.ok_cnt + 2'h1 : 2'h0;
			// Third good reading in a row, or the cap reached
			if ((in_win && q.ok_cnt == 2'(`SETTLE_OK - 1)) || q.iter == 4'(`SETTLE_MAX - 1)) begin
				d.settling = 1'b0;
				if (!in_win) begin
					ev[q.cmode ? `S_ICMP : `S_VCMP] = 1'b1;
				end
			end
		end
		// Limit crossover checks once the output has settled
		if (!q.settling && tick) begin
			if (!q.cmode && ADC_I >= q.iset) begin
				ev[`S_OVLD] = 1'b1;
			end
			if (q.cmode && ADC_V >= q.vset) begin
				ev[`S_OVLD] = 1'b1;
			end
		end
		// Register writes
		if (req.wr) begin
			case (req.addr)
				`A_CTRL: begin
					d.cmode = req.wdata[`C_CMODE];
					d.relay_var = req.wdata[`C_RELAY];
					// Clearing shutdown is software's call after a fault
					if (req.wdata[`C_CLRSD]) begin
						d.sd = '0;
					end
				end
				`A_VSET: d.vset = req.wdata[11:0];
				`A_ISET: d.iset = req.wdata[11:0];
				`A_MASK: d.mask = req.wdata[`EV_W-1:0];
				default: begin
				end
			endcase
			// A programming change opens a fresh settling window
			if (req.addr == `A_CTRL || req.addr == `A_VSET || req.addr == `A_ISET) begin
				d.settling = 1'b1;
				d.ok_cnt = 2'h0;
				d.iter = 4'h0;
			end
		end
		// Sticky status: write one clears, new event wins, masked in sequences
		d.status = q.status;
		if (req.wr && req.addr == `A_STAT) begin
			d.status = q.status & ~req.wdata[`EV_W-1:0];
		end
		if (!SEQ_BUSY) begin
			d.status = d.status | ev;
		end
		// Register reads, answered in the next cycle
		if (req.rd) begin
			case (req.addr)
				`A_CTRL: d.rdata = {30'h0, q.relay_var, q.cmode};
				`A_VSET: d.rdata = {20'h0, q.vset};
				`A_ISET: d.rdata = {20'h0, q.iset};
				`A_VMEAS: d.rdata = {20'h0, q.vmeas};
				`A_IMEAS: d.rdata = {20'h0, q.imeas};
				`A_STAT: d.rdata = {25'h0, q.status};
				`A_MASK: d.rdata = {25'h0, q.mask};
				`A_STATE: d.rdata = {27'h0, q.settling, q.sd};
				default: d.rdata = 32'h0;
			endcase
		end
		// References go to zero while any shutdown action stands
		d.vref = d.sd.zero ? 12'h0 : d.vset;
		d.iref = d.sd.zero ? 12'h0 : d.iset;
		// Interrupts follow status in the same cycle as the event
		d.irq = |(d.status & d.mask);
		d.hp_irq = |d.status[`S_PATH:`S_CROW];
	end

	// State register with synchronous reset
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state register
	assign RDATA = q.rdata;
	assign VREF = q.vref;
	assign IREF = q.iref;
	assign IRQ = q.irq;
	assign HP_IRQ = q.hp_irq;
	assign CROWBAR = q.sd.crowbar;
	assign BREAKER_TRIP = q.sd.trip;
	assign ZERO_OUT = q.sd.zero;
	assign RELAY_OPEN = q.sd.relay_open;

	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	// Setpoint write reaches the register next cycle
	vset_store_a: assert property (WR && ADDR == `A_VSET |=> q.vset == $past(WDATA[11:0]))
		else $error("voltage setpoint not stored");
	// Buffer changes only on a loop tick
	meas_tick_a: assert property (!tick |=> $stable(q.vmeas) && $stable(q.imeas))
		else $error("measurement buffer changed off tick");
	// Read of voltage buffer returns it next cycle
	meas_read_a: assert property (RD && ADDR == `A_VMEAS |=> RDATA == {20'h0, $past(q.vmeas)})
		else $error("measurement read mismatch");
	// Settling never outlasts ten iterations
	settle_cap_a: assert property (q.iter <= 4'(`SETTLE_MAX))
		else $error("settling exceeded cap");
	// Three good readings end settling
	sequence good3_s;
		q.settling && tick && in_win && q.ok_cnt == 2'h2 && !WR;
	endsequence
	settle_end_a: assert property (good3_s |=> !q.settling)
		else $error("settling did not end");
	// Overload event reaches status unless masked
	ovld_flag_a: assert property (!q.settling && tick && !q.cmode && ADC_I >= q.iset && !SEQ_BUSY
		|=> q.status[`S_OVLD])
		else $error("overload not flagged");
	// Timer restarts when its condition drops
	tmr_clear_a: assert property (!raw[T_OVC] |=> q.tmr[T_OVC] == '0)
		else $error("timer did not restart");
	// Crowbar brings trip, error and high interrupt together
	sequence crow_rise_s;
		$rose(q.sd.crowbar);
	endsequence
	// A masked sequence holds back the error, and with it the high-priority interrupt
	crow_report_a: assert property (crow_rise_s |-> q.sd.trip && ($past(SEQ_BUSY) || (q.status[`S_CROW] && q.hp_irq)))
		else $error("crowbar without report");
	// Masked sequence keeps new errors out
	seq_mask_a: assert property (SEQ_BUSY && !(WR && ADDR == `A_STAT) |=> q.status == $past(q.status))
		else $error("error captured during sequence");
	// Path fault on relay unit opens relays and zeroes output
	path_act_a: assert property (qual[T_PATH] && q.relay_var |=> q.sd.relay_open && q.sd.zero)
		else $error("path fault action missing");
endmodule
`default_nettype wire

// *** shared/supmon_params.svh ***
// Constants of the supply monitor and fault supervisor
// How it works
// - Voltage and current setpoints, 12 bits each
// - Both measurement buffers refresh every 2 ms
// - Measurement buffers returned only when read
// - Settling ends after three in-window readings
// - Settling capped at ten loop iterations
// - Deviation over 0.6% full scale flags error
// - Voltage mode current limit raises overload
// - Current mode voltage limit raises overload
// - Shutdown faults drive high-priority interrupt
// - Over 10% margin for 6 ms crowbars
// - Overtemperature errors, crowbar after 6 ms
// - Power loss 8 ms plus 6 ms crowbars
// - Path fault persists 6 or 20 ms
// - Path fault zeroes output, opens or crowbars
// - Path fault reported in the same cycle as power removal
// - Crowbar reports, shorts output, trips breaker
// - Error capture masked during switching sequences
`ifndef SUPMON_PARAMS_SVH
`define SUPMON_PARAMS_SVH
// Clock rate in MHz
`define CLK_MHZ 100
// Times in microseconds
`define T_LOOP_US 2000
`define T_PERSIST_US 6000
`define T_PLDET_US 8000
`define T_PATHR_US 20000
// Settling figures
`define SETTLE_OK 3
`define SETTLE_MAX 10
// 0.6% of 4095 counts, rounded down
`define CMP_TOL 12'h018
// 10% of 4095 counts
`define OVC_MARGIN 12'h199
// Register offsets (byte addresses)
`define A_CTRL 8'h00
`define A_VSET 8'h04
`define A_ISET 8'h08
`define A_VMEAS 8'h0c
`define A_IMEAS 8'h10
`define A_STAT 8'h14
`define A_MASK 8'h18
`define A_STATE 8'h1c
// Control bit positions
`define C_CMODE 0
`define C_RELAY 1
`define C_CLRSD 2
// Status bit positions
`define S_VCMP 0
`define S_ICMP 1
`define S_OVLD 2
`define S_CROW 3
`define S_OTMP 4
`define S_PLOSS 5
`define S_PATH 6
`define EV_W 7
`define TMR_W 21
`endif

// *** shared/supmon_pkg.sv ***
// Types of the supply monitor and fault supervisor
`include "supmon_params.svh"
package supmon_pkg;
	// Timer index of each persistence timer
	typedef enum logic [1:0] {T_OVC, T_OTMP, T_PLOSS, T_PATH} tmr_idx_t;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
	// Shutdown actions
	typedef struct packed {
		logic crowbar;
		logic trip;
		logic zero;
		logic relay_open;
	} sd_t;
	// Whole state of the supervisor
	typedef struct packed {
		logic [31:0] rdata;
		logic cmode;
		logic relay_var;
		logic [11:0] vset;
		logic [11:0] iset;
		logic [11:0] vref;
		logic [11:0] iref;
		logic [11:0] vmeas;
		logic [11:0] imeas;
		logic [17:0] tick_cnt;
		logic settling;
		logic [1:0] ok_cnt;
		logic [3:0] iter;
		logic [3:0][`TMR_W-1:0] tmr;
		logic ot_prev;
		logic [`EV_W-1:0] status;
		logic [`EV_W-1:0] mask;
		logic irq;
		logic hp_irq;
		sd_t sd;
	} state_t;
endpackage

// *** sim/remote_ctl_model.sv ***
// Remote controller model: register accesses from the bus side
`timescale 1ns/10ps
`default_nettype none
module remote_ctl_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	// Idle bus from time zero, so reset sees no access
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One-cycle write; the slave never stalls
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Values travel only on request; data stand one cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
endmodule
`default_nettype wire

// *** sim/supply_monitor_fault_supervisor_tb.sv ***
// Self-checking bench of the supply supervisor
`timescale 1ns/10ps
`default_nettype none
`include "supmon_params.svh"
module supply_monitor_fault_supervisor_tb import supmon_pkg::*;;
	// Short loop tick keeps the run brief
	localparam int TC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr, rd;
	// Plant and sensors, quiet at time zero
	logic [11:0] av = 12'h000, ai = 12'h000;
	logic ot = 1'b0, pl = 1'b0, pdo = 1'b0, pdc = 1'b0, jmp = 1'b1, busy = 1'b0;
	logic [11:0] vref, iref;
	logic irq, hp, cb, trip, zo, ro;
	int n_mismatch = 0, n_compared = 0, cnt = 0;
	supply_monitor_fault_supervisor #(.TICK_CYC(TC), .P6_CYC(50), .PLDET_CYC(60), .P20_CYC(150)) dut (
		.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.ADC_V(av), .ADC_I(ai), .OVERTEMP(ot), .POWER_LOST(pl), .PATH_DROP_OUT(pdo),
		.PATH_DROP_COMMON_SENSE_LEAD(pdc), .POWER_LOSS_DISABLE_JUMPER(jmp), .SEQ_BUSY(busy),
		.VREF(vref), .IREF(iref), .IRQ(irq), .HP_IRQ(hp), .CROWBAR(cb), .BREAKER_TRIP(trip),
		.ZERO_OUT(zo), .RELAY_OPEN(ro));
	remote_ctl_model ctl (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	// Clock of 10 ns
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Case equality, so an unknown never matches
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Voltage setpoint keeps 12 bits; the voltage buffer follows the converter
	task automatic t_regs;
		ctl.wr_reg(`A_VSET, 32'hffff_fabc);
		@(negedge clk);
		chk("vref", 32'habc, {20'h0, vref});
		ctl.rd_reg(`A_VSET, d);
		chk("vset", 32'habc, d);
		cyc(1);
		av <= 12'h321;
		cyc(TC + 1);
		ctl.rd_reg(`A_VMEAS, d);
		chk("vmeas", 32'h321, d);
		ctl.rd_reg(8'h20, d);
		chk("unmapped", 32'h0, d);
	endtask
	// Offset at the window edge settles early; one count more errs at the cap
	task automatic t_settle(input logic cm, input logic [11:0] off);
		logic bad;
		bad = off > 12'h018;
		av <= cm ? 12'h000 : 12'h400 + off;
		ai <= cm ? 12'h400 + off : 12'h000;
		ctl.wr_reg(`A_CTRL, {31'h0, cm});
		ctl.wr_reg(`A_VSET, cm ? 32'hfff : 32'h400);
		ctl.wr_reg(`A_ISET, cm ? 32'h400 : 32'hfff);
		ctl.wr_reg(`A_STAT, 32'h7f);
		cyc(4 * TC);
		ctl.rd_reg(`A_STATE, d);
		chk("settling", {27'h0, bad, 4'h0}, d & 32'h10);
		cyc(7 * TC);
		ctl.rd_reg(`A_STAT, d);
		chk("cmp err", {30'h0, bad & cm, bad & ~cm}, d & 32'h3);
	endtask
	// Limit reached exactly at the crossover raises overload
	task automatic t_ovl(input logic cm);
		ctl.wr_reg(`A_CTRL, {31'h0, cm});
		ctl.wr_reg(`A_VSET, 32'h400);
		ctl.wr_reg(`A_ISET, 32'h200);
		av <= cm ? 12'h3ff : 12'h400;
		ai <= cm ? 12'h200 : 12'h1ff;
		cyc(6 * TC);
		ctl.wr_reg(`A_STAT, 32'h7f);
		cyc(2 * TC);
		ctl.rd_reg(`A_STAT, d);
		chk("no ovld", 32'h0, d & 32'h4);
		cyc(1);
		av <= 12'h400;
		ai <= 12'h200;
		ctl.wr_reg(`A_MASK, 32'h4);
		cyc(2 * TC);
		@(negedge clk);
		chk("irq on", 32'h1, {31'h0, irq});
		ctl.wr_reg(`A_MASK, 32'h0);
		cyc(1);
		@(negedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
	endtask
	// Raw condition of each fault case
	task automatic drive(input int k, input logic v);
		case (k)
			0: av <= v ? 12'h29a : 12'h000;
			1, 6: ot <= v;
			2, 3: pl <= v;
			4: pdo <= v;
			default: pdc <= v;
		endcase
	endtask
	// A pulse three cycles short of the limit and a one-cycle drop first: a timer that failed to restart would fire early
	task automatic t_fault(input int k);
		int lim;
		logic [6:0] es, sm;
		logic [3:0] ea, am;
		lim = (k == 2 || k == 3) ? 110 : (k == 5 ? 150 : 50);
		// Power loss reports its own error beside the crowbar error
		es = k == 1 ? 7'h18 : k == 0 ? 7'h08 : k == 2 ? 7'h28 : (k == 4 || k == 5) ? 7'h40 : 7'h00;
		sm = (k == 4 || k == 5) ? 7'h70 : 7'h78;
		ea = k == 3 ? 4'h0 : k == 4 ? 4'h2 : k == 5 ? 4'h3 : 4'he;
		am = k == 4 ? 4'h2 : k == 5 ? 4'h3 : 4'hf;
		jmp <= (k != 3);
		busy <= (k == 6);
		ctl.wr_reg(`A_CTRL, k == 5 ? 32'h6 : 32'h4);
		ctl.wr_reg(`A_VSET, 32'h100);
		ctl.wr_reg(`A_STAT, 32'h7f);
		drive(k, 1'b1);
		cyc(lim - 3);
		drive(k, 1'b0);
		cyc(1);
		drive(k, 1'b1);
		cyc(lim - 2);
		@(negedge clk);
		chk("early act", 32'h0, {28'h0, cb, trip, zo, ro});
		ctl.rd_reg(`A_STAT, d);
		chk("early stat", k == 1 ? 32'h10 : 32'h0, d & 32'h18);
		cyc(6);
		@(negedge clk);
		chk("act", {28'h0, ea}, {28'h0, am & {cb, trip, zo, ro}});
		chk("hp irq", {31'h0, |es[6:3]}, {31'h0, hp});
		if (ea[1]) begin
			chk("zero ref", 32'h0, {8'h0, vref, iref});
		end
		ctl.rd_reg(`A_STAT, d);
		chk("fault stat", {25'h0, es}, d & {25'h0, sm});
		cyc(1);
		drive(k, 1'b0);
		busy <= 1'b0;
		ctl.wr_reg(`A_CTRL, 32'h4);
		ctl.wr_reg(`A_STAT, 32'h7f);
		cyc(1);
		@(negedge clk);
		chk("cleared", 32'h0, {27'h0, hp, cb, trip, zo, ro});
	endtask
	// Main sequence after 8 cycles of reset
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_settle(1'b0, 12'h018);
		t_settle(1'b0, 12'h019);
		t_settle(1'b1, 12'h018);
		t_settle(1'b1, 12'h019);
		t_ovl(1'b0);
		t_ovl(1'b1);
		for (int k = 0; k < 7; k++) begin
			t_fault(k);
		end
		report_and_stop();
	end
	// Hang guard; the sequence needs some 3000 cycles
	always @(posedge clk) begin
		cnt <= cnt + 1;
		if (cnt == 30000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
